// [rtl/scbg_baud_div.v]
// Baud divider: optional divide-by-four prescaler and 11-bit reload divider, 50% duty except odd divisors on undivided main clock.
// Assumes step counts source half periods seen in one pclk cycle (0, 1 or 2).
`timescale 1ns/1ps
`include "scbg_consts.vh"

module scbg_baud_div (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire [1:0]  step,
    input  wire        prescale,
    input  wire [10:0] divider,
    output reg         gen_clk_r,
    output reg         toggle_r
);
    reg  [2:0]  pre_acc_r;
    reg  [11:0] acc_r;
    reg  [11:0] divisor_r;
    reg         prescale_r;
    reg  [2:0]  pre_sum;
    reg  [1:0]  pstep;
    reg  [11:0] acc_sum;
    wire [11:0] div_plus;

    assign div_plus = {1'b0, divider} + 12'h001;

    always @* begin
        pre_sum = pre_acc_r + {1'b0, step};
        pstep   = step;
        if (prescale_r) begin
            pstep = (pre_sum >= `SCBG_PRESCALE_HALVES) ? 2'h1 : 2'h0;
        end
        acc_sum = acc_r + {10'h000, pstep};
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_acc_r  <= 3'h0;
            acc_r      <= 12'h000;
            divisor_r  <= 12'h003;
            prescale_r <= 1'b0;
            gen_clk_r  <= 1'b0;
            toggle_r   <= 1'b0;
        end else if (ce) begin
            toggle_r <= 1'b0;
            if (prescale_r && pre_sum >= `SCBG_PRESCALE_HALVES) begin
                pre_acc_r <= pre_sum - `SCBG_PRESCALE_HALVES;
            end else if (prescale_r) begin
                pre_acc_r <= pre_sum;
            end
            // each terminal count toggles; odd divisors alternate phases
            if (acc_sum >= divisor_r) begin
                acc_r     <= acc_sum - divisor_r;
                gen_clk_r <= ~gen_clk_r;
                toggle_r  <= 1'b1;
                // divisor is field plus one, never below two
                divisor_r  <= (div_plus < `SCBG_MIN_DIVISOR) ? `SCBG_MIN_DIVISOR : div_plus;
                prescale_r <= prescale;
                if (prescale != prescale_r) begin
                    pre_acc_r <= 3'h0;
                end
            end else begin
                acc_r <= acc_sum;
            end
        end
    end
endmodule // scbg_baud_div

// [rtl/scbg_consts.vh]
// Constants of the serial channel baud clock generator: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef SCBG_CONSTS_VH
`define SCBG_CONSTS_VH

// Register byte offsets on APB
`define SCBG_OFF_CONFIG      12'h000
`define SCBG_OFF_CONTROL     12'h004
`define SCBG_OFF_STATUS      12'h008

// Channel configuration register fields
`define SCBG_CFG_RESET       16'h0004
`define SCBG_BIT_OPEN_DRAIN  15
`define SCBG_BIT_EXT_SOURCE  14
`define SCBG_BIT_TX_SOURCE   13
`define SCBG_BIT_RX_SOURCE   12
`define SCBG_DIV_MSB         11
`define SCBG_DIV_LSB         1
`define SCBG_BIT_PRESCALE    0

// Control register fields
`define SCBG_CTL_RESET       3'h0
`define SCBG_BIT_ASYNC       2
`define SCBG_DIAG_MSB        1
`define SCBG_DIAG_LSB        0
`define SCBG_DIAG_NORMAL     2'h0
`define SCBG_DIAG_LOOPBACK   2'h1
`define SCBG_DIAG_ECHO       2'h2

// Timing: half periods per source clock, prescale factor, async oversampling
`define SCBG_HALF_PER_PCLK   2'h2
`define SCBG_PRESCALE_HALVES 3'h4
`define SCBG_MIN_DIVISOR     12'h002
`define SCBG_ASYNC_OVERSMP   4'hf

`endif

// [rtl/scbg_top.v]
// Serial channel baud clock generator with APB registers, clock pin steering and diagnostics.
// Assumes one pclk domain; pins and timer input are asynchronous and are synchronised here.
//
// Function
// - Configuration register resets to 0x0004, generator dividing main clock by three.
// - Bit 15 set makes transmit data open drain, else actively driven.
// - Bit 14 selects main clock or shared timer input as generator source.
// - Bit 13 zero uses generator for transmit and drives it on pin.
// - Transmit clock pin stays input after reset until a zero is written.
// - Bit 12 zero uses generator for receive and drives it on pin.
// - Receive clock pin stays input after reset until a zero is written.
// - Divider field plus one is reloaded at each terminal count as the limit of a hidden 12-bit up-counting accumulator.
// - Divider field sets rate; all ones slowest, all zeros divides by two.
// - Output keeps 50% duty, terminal counts alternate phases and toggle; odd divisors on undivided main clock give halves one pclk apart.
// - Bit 0 inserts a divide-by-four prescaler, else input passes undivided.
// - Asynchronous operation uses a clock sixteen times the bit rate.
// - Async bit rate is source over prescale over divisor over sixteen.
// - Async bit rate from a clock pin is pin clock over sixteen.
// - Synchronous bit clock equals the generator output directly.
// - Generator output is always available on its own pin.
// - Transmitter and receiver run independently on their own clocks.
// - Echo mode retransmits received data; loopback feeds transmit to receive.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "scbg_consts.vh"

module scbg_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        timer_input_one,
    input  wire        tx_clock_pin_i,
    output reg         tx_clock_pin_o,
    output reg         tx_clock_pin_oe,
    input  wire        rx_clock_pin_i,
    output reg         rx_clock_pin_o,
    output reg         rx_clock_pin_oe,
    output reg         brg_clk_out,
    input  wire        tx_data_in,
    output reg         txd_o,
    output reg         txd_oe,
    input  wire        rxd_i,
    output reg         rx_data_out,
    output reg         tx_bit_tick,
    output reg         rx_bit_tick
);
    reg  [15:0] cfg_r;
    reg  [2:0]  ctl_r;
    reg         tx_drive_ok_r;
    reg         rx_drive_ok_r;
    reg  [3:0]  sync1_r;
    reg  [3:0]  sync2_r;
    reg  [3:0]  sync3_r;
    reg  [3:0]  filt_r;
    reg  [3:0]  filt_d_r;
    reg         gen_d_r;
    reg  [3:0]  tx_os_r;
    reg  [3:0]  rx_os_r;
    reg  [1:0]  step;
    reg  [31:0] rd_data;
    reg         addr_ok;
    wire [3:0]  async_in;
    wire [3:0]  rise;
    wire [3:0]  fall;
    wire        gen_clk;
    wire        gen_rise;
    wire        tx_edge;
    wire        rx_edge;
    wire        wr_en;
    wire        tx_drive;
    wire        rx_drive;
    wire        txd_val;

    assign async_in = {rxd_i, rx_clock_pin_i, tx_clock_pin_i, timer_input_one};

    // Three-stage synchronisers; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            // Reset to the pin's idle level so no false edge follows reset; receive data idles high
            localparam [0:0] idle_lvl = (gi == 3) ? 1'b1 : 1'b0;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r[gi]  <= idle_lvl;
                    sync2_r[gi]  <= idle_lvl;
                    sync3_r[gi]  <= idle_lvl;
                    filt_r[gi]   <= idle_lvl;
                    filt_d_r[gi] <= idle_lvl;
                end else if (ce) begin
                    sync1_r[gi]  <= async_in[gi];
                    sync2_r[gi]  <= sync1_r[gi];
                    sync3_r[gi]  <= sync2_r[gi];
                    filt_d_r[gi] <= filt_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        filt_r[gi] <= sync3_r[gi];
                    end
                end
            end
            assign rise[gi] = filt_r[gi] & ~filt_d_r[gi];
            assign fall[gi] = ~filt_r[gi] & filt_d_r[gi];
        end
    endgenerate

    always @* begin
        if (cfg_r[`SCBG_BIT_EXT_SOURCE]) begin
            // Both timer edges count, so odd divisors still give exact halves
            step = (rise[0] | fall[0]) ? 2'h1 : 2'h0;
        end else begin
            // Main clock offers no half cycles; odd divisors are within one pclk
            step = `SCBG_HALF_PER_PCLK;
        end
    end

    scbg_baud_div u_div (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .step      (step),
        .prescale  (cfg_r[`SCBG_BIT_PRESCALE]),
        .divider   (cfg_r[`SCBG_DIV_MSB:`SCBG_DIV_LSB]),
        .gen_clk_r (gen_clk),
        .toggle_r  ()
    );

    assign gen_rise = gen_clk & ~gen_d_r;
    assign tx_edge  = cfg_r[`SCBG_BIT_TX_SOURCE] ? rise[1] : gen_rise;
    assign rx_edge  = cfg_r[`SCBG_BIT_RX_SOURCE] ? rise[2] : gen_rise;
    // pin drives only after a zero was written
    assign tx_drive = tx_drive_ok_r & ~cfg_r[`SCBG_BIT_TX_SOURCE];
    // pin drives only after a zero was written
    assign rx_drive = rx_drive_ok_r & ~cfg_r[`SCBG_BIT_RX_SOURCE];
    // echo sends received data back out
    assign txd_val  = (ctl_r[`SCBG_DIAG_MSB:`SCBG_DIAG_LSB] == `SCBG_DIAG_ECHO) ?
                      filt_r[3] : tx_data_in;
    assign wr_en    = psel & penable & pready & pwrite;

    always @* begin
        rd_data = 32'h00000000;
        addr_ok = 1'b1;
        case (paddr)
            `SCBG_OFF_CONFIG:  rd_data = {16'h0000, cfg_r};
            `SCBG_OFF_CONTROL: rd_data = {29'h00000000, ctl_r};
            `SCBG_OFF_STATUS:  rd_data = {28'h0000000, rx_drive, tx_drive, filt_r[0], gen_clk};
            default:           addr_ok = 1'b0;
        endcase
    end

    // APB slave: one wait state, pready raised on the second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce) begin
            if (psel && penable && !pready) begin
                pready  <= 1'b1;
                prdata  <= pwrite ? 32'h00000000 : rd_data;
                pslverr <= ~addr_ok;
            end else begin
                pready  <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r         <= `SCBG_CFG_RESET;
            ctl_r         <= `SCBG_CTL_RESET;
            tx_drive_ok_r <= 1'b0;
            rx_drive_ok_r <= 1'b0;
        end else if (ce && wr_en) begin
            if (paddr == `SCBG_OFF_CONFIG) begin
                cfg_r <= pwdata[15:0];
                if (!pwdata[`SCBG_BIT_TX_SOURCE]) begin
                    tx_drive_ok_r <= 1'b1;
                end
                if (!pwdata[`SCBG_BIT_RX_SOURCE]) begin
                    rx_drive_ok_r <= 1'b1;
                end
            end
            if (paddr == `SCBG_OFF_CONTROL) begin
                ctl_r <= pwdata[2:0];
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_d_r         <= 1'b0;
            tx_os_r         <= 4'h0;
            rx_os_r         <= 4'h0;
            tx_clock_pin_o  <= 1'b0;
            tx_clock_pin_oe <= 1'b0;
            rx_clock_pin_o  <= 1'b0;
            rx_clock_pin_oe <= 1'b0;
            brg_clk_out     <= 1'b0;
            txd_o           <= 1'b1;
            txd_oe          <= 1'b1;
            rx_data_out     <= 1'b1;
            tx_bit_tick     <= 1'b0;
            rx_bit_tick     <= 1'b0;
        end else if (ce) begin
            gen_d_r         <= gen_clk;
            brg_clk_out     <= gen_clk;
            tx_clock_pin_o  <= gen_clk;
            tx_clock_pin_oe <= tx_drive;
            rx_clock_pin_o  <= gen_clk;
            rx_clock_pin_oe <= rx_drive;
            if (cfg_r[`SCBG_BIT_OPEN_DRAIN]) begin
                txd_o  <= 1'b0;
                txd_oe <= ~txd_val;
            end else begin
                txd_o  <= txd_val;
                txd_oe <= 1'b1;
            end
            if (ctl_r[`SCBG_DIAG_MSB:`SCBG_DIAG_LSB] == `SCBG_DIAG_LOOPBACK) begin
                rx_data_out <= tx_data_in;
            end else begin
                rx_data_out <= filt_r[3];
            end
            tx_bit_tick <= 1'b0;
            rx_bit_tick <= 1'b0;
            // async divides the serial clock by sixteen
            if (tx_edge) begin
                tx_os_r <= tx_os_r + 4'h1;
                if (!ctl_r[`SCBG_BIT_ASYNC] || tx_os_r == `SCBG_ASYNC_OVERSMP) begin
                    tx_bit_tick <= 1'b1;
                end
            end
            if (rx_edge) begin
                rx_os_r <= rx_os_r + 4'h1;
                if (!ctl_r[`SCBG_BIT_ASYNC] || rx_os_r == `SCBG_ASYNC_OVERSMP) begin
                    rx_bit_tick <= 1'b1;
                end
            end
        end
    end
endmodule // scbg_top

// [testbench/scbg_asserts.sv]
// Checker: APB handshake, clock pin drive, transmit bit tick, transmit pin drive.
// Assumes binding onto scbg_top; config and mode shadowed from APB writes.
`timescale 1ns/1ps
`include "scbg_consts.vh"
module scbg_asserts (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tx_clock_pin_o,
    input wire        tx_clock_pin_oe,
    input wire        rx_clock_pin_o,
    input wire        rx_clock_pin_oe,
    input wire        brg_clk_out,
    input wire        txd_o,
    input wire        txd_oe,
    input wire        tx_bit_tick
);
    reg  [15:0] cfg_r;
    reg         async_r;
    wire        wr_ok = ce && psel && penable && pready && pwrite && !pslverr;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r   <= `SCBG_CFG_RESET;
            async_r <= 1'b0;
        end else if (wr_ok && paddr == `SCBG_OFF_CONFIG) begin
            cfg_r <= pwdata[15:0];
        end else if (wr_ok && paddr == `SCBG_OFF_CONTROL) begin
            async_r <= pwdata[`SCBG_BIT_ASYNC];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready && ce;
    endsequence
    // Mode and pin drive settled for a cycle, so the tick mux has caught up
    sequence s_sync_gen;
        !async_r && !$past(async_r) && tx_clock_pin_oe && $past(tx_clock_pin_oe);
    endsequence
    a_ready_one_wait: assert property (s_wait |=> pready)
        else $error("pready late");
    a_ready_one_cycle: assert property (pready && ce |=> !pready)
        else $error("pready held");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_tx_pin_follows: assert property (tx_clock_pin_oe |-> tx_clock_pin_o == brg_clk_out)
        else $error("tx pin not generator");
    a_rx_pin_follows: assert property (rx_clock_pin_oe |-> rx_clock_pin_o == brg_clk_out)
        else $error("rx pin not generator");
    a_tx_pin_armed: assert property ($rose(tx_clock_pin_oe) |->
        !cfg_r[`SCBG_BIT_TX_SOURCE] && ($past(wr_ok) || $past(wr_ok, 2) || $past(wr_ok, 3)))
        else $error("tx pin driven without write");
    a_sync_tick: assert property (s_sync_gen ##0 $rose(brg_clk_out) |-> tx_bit_tick)
        else $error("sync tick missing");
    a_tick_single: assert property (tx_bit_tick && ce |=> !tx_bit_tick)
        else $error("tick too long");
    a_txd_released: assert property (cfg_r[15] && $past(cfg_r[15]) && txd_oe |-> !txd_o)
        else $error("open drain drove high");
    a_txd_driven: assert property (!cfg_r[15] && !$past(cfg_r[15]) |-> txd_oe)
        else $error("txd not driven");
endmodule // scbg_asserts
bind scbg_top scbg_asserts chk (
    .pclk            (pclk),
    .presetn         (presetn),
    .ce              (ce),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .tx_clock_pin_o  (tx_clock_pin_o),
    .tx_clock_pin_oe (tx_clock_pin_oe),
    .rx_clock_pin_o  (rx_clock_pin_o),
    .rx_clock_pin_oe (rx_clock_pin_oe),
    .brg_clk_out     (brg_clk_out),
    .txd_o           (txd_o),
    .txd_oe          (txd_oe),
    .tx_bit_tick     (tx_bit_tick)
);

// [testbench/scbg_line_model.sv]
// Far-side line equipment: clock pin sources and the shared timer input.
// Assumes the bench runs a pin source only while the block listens on it.
`timescale 1ns/1ps
module scbg_line_model #(
    parameter HALF_TX  = 40,
    parameter HALF_RX  = 24,
    parameter HALF_TMR = 40
) (
    input  logic run_tx,
    input  logic run_rx,
    input  logic run_tmr,
    output logic tx_clk,
    output logic rx_clk,
    output logic tmr_clk
);
    initial {tx_clk, rx_clk, tmr_clk} = 3'h0;
    // pin clocks slower than pclk over 2.5
    // Edges on multiples of 8 ns stay clear of rising pclk; idle clocks rest low
    always #(HALF_TX) tx_clk = run_tx ? ~tx_clk : 1'b0;
    always #(HALF_RX) rx_clk = run_rx ? ~rx_clk : 1'b0;
    always #(HALF_TMR) tmr_clk = run_tmr ? ~tmr_clk : 1'b0;
endmodule // scbg_line_model

// [testbench/test_serial_channel_baud_clock_gen.sv]
// Bench: register access, generator rates, clock pins, diagnostics, txd drive.
// Assumes scbg_top plus the line model on its pins; ce stays high.
`timescale 1ns/1ps
`include "scbg_consts.vh"
module test_serial_channel_baud_clock_gen;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        txo, txe, rxo, rxe, brg, tdi, txd, txde, rxd, rxdo, ttk, rtk;
    logic        m_tx, m_rx, m_tm, run_tx, run_rx, run_tm;
    int          fail_count, num_checks, per, hi, ep;
    int          cyc = 0;
    logic [15:0] cfgs [5] = '{16'h0004, 16'h0000, 16'h0006, 16'h0005, 16'h0ffe};
    wire         tx_w = txe ? txo : m_tx;
    wire         rx_w = rxe ? rxo : m_rx;
    scbg_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_one(m_tm), .tx_clock_pin_i(tx_w),
        .tx_clock_pin_o(txo), .tx_clock_pin_oe(txe), .rx_clock_pin_i(rx_w),
        .rx_clock_pin_o(rxo), .rx_clock_pin_oe(rxe), .brg_clk_out(brg), .tx_data_in(tdi),
        .txd_o(txd), .txd_oe(txde), .rxd_i(rxd), .rx_data_out(rxdo), .tx_bit_tick(ttk),
        .rx_bit_tick(rtk));
    scbg_line_model line (.run_tx(run_tx), .run_rx(run_rx), .run_tmr(run_tm), .tx_clk(m_tx),
        .rx_clk(m_rx), .tmr_clk(m_tm));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Whole run is under 20k cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function logic pick(input int w);
        return w == 0 ? brg : (w == 1 ? ttk : rtk);
    endfunction
    // Rise to rise distance and high time; the first of two passes resyncs after a change
    task rate(input int w, input int exp);
        logic p, s;
        int n, k;
        repeat (2) begin
            {p, per, hi, n, k} = '1;
            {per, hi, n, k} = '0;
            while (n < 2 && k < 20000) begin
                @(posedge pclk);
                k++;
                s = pick(w);
                if (s === 1'b1 && p === 1'b0) n++;
                if (n == 1) per++;
                if (n == 1 && s === 1'b1) hi++;
                p = s;
            end
        end
        check("period", per, exp);
    endtask
    function int div_of(input logic [15:0] c);
        int d;
        d = int'(c[11:1]) + 1;
        if (d < 2) d = 2;
        return c[0] ? 4 * d : d;
    endfunction
    initial begin
        {fail_count, num_checks} = '0;
        {psel, penable, pwrite, run_tx, run_rx, run_tm, presetn} = '0;
        {tdi, rxd, ce} = 3'h7;
        paddr = '0;
        pwdata = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `SCBG_OFF_CONFIG, 0);
        check("config", rd, 32'h4);
        apb(0, `SCBG_OFF_CONTROL, 0);
        check("control", rd, 32'h0);
        apb(0, 12'h00c, 0);
        check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        apb(1, `SCBG_OFF_CONFIG, 32'h3004);
        check("tx oe", txe, 0);
        check("rx oe", rxe, 0);
        rate(0, 3);
        apb(1, `SCBG_OFF_CONFIG, 32'h4);
        apb(0, `SCBG_OFF_STATUS, 0);
        check("pins", {rd[3:2], txe, rxe}, 4'hf);
        foreach (cfgs[i]) begin
            apb(1, `SCBG_OFF_CONFIG, {16'h0, cfgs[i]});
            ep = div_of(cfgs[i]);
            rate(0, ep);
            if (ep % 2 == 0) check("high", hi, ep / 2);
        end
        run_tm <= 1'b1;
        apb(1, `SCBG_OFF_CONFIG, 32'h4002);
        rate(0, 20);
        // Odd divisor from the timer: both timer edges count, so halves are exact
        apb(1, `SCBG_OFF_CONFIG, 32'h4004);
        rate(0, 30);
        check("odd high", hi, 15);
        run_tm <= 1'b0;
        apb(1, `SCBG_OFF_CONFIG, 32'h4);
        rate(1, 3);
        apb(1, `SCBG_OFF_CONTROL, 32'h4);
        rate(1, 48);
        apb(1, `SCBG_OFF_CONFIG, 32'h3004);
        run_tx <= 1'b1;
        run_rx <= 1'b1;
        rate(1, 160);
        rate(2, 96);
        apb(1, `SCBG_OFF_CONTROL, 32'h0);
        rate(2, 6);
        {run_tx, run_rx} <= 2'h0;
        apb(1, `SCBG_OFF_CONTROL, 32'h1);
        rxd <= 1'b0;
        repeat (8) @(posedge pclk);
        check("loop", rxdo, 1);
        tdi <= 1'b0;
        repeat (8) @(posedge pclk);
        check("loop", rxdo, 0);
        apb(1, `SCBG_OFF_CONTROL, 32'h2);
        tdi <= 1'b1;
        repeat (8) @(posedge pclk);
        check("echo", txd, 0);
        apb(1, `SCBG_OFF_CONTROL, 32'h0);
        apb(1, `SCBG_OFF_CONFIG, 32'h8004);
        repeat (4) @(posedge pclk);
        check("txd oe", txde, 0);
        tdi <= 1'b0;
        repeat (4) @(posedge pclk);
        check("txd low", {txde, txd}, 2'h2);
        tally_and_finish;
    end
endmodule // test_serial_channel_baud_clock_gen
